/* File: src/restart_pkg.sv */
// shared constants and carrier types for the supply-fault restart controller
// assumes a 100 MHz control clock; times are held in units of 0.1 s
package restart_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_UV_TIME = 4'h1;
    localparam logic [3:0] ADDR_WAIT_TIME = 4'h2;
    localparam logic [3:0] ADDR_ALARM_EN = 4'h3;
    localparam logic [3:0] ADDR_COUNT_POL = 4'h4;
    localparam logic [3:0] ADDR_FREQ_THR = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_COUNTS = 4'h7;

    // ------------------------------------------------------------
    // codes and limits
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_TRIP = 2'h0;
    localparam logic [1:0] MODE_ZERO = 2'h1;
    localparam logic [1:0] MODE_MATCH = 2'h2;
    localparam logic [1:0] MODE_MATCH_STOP = 2'h3;
    localparam logic [1:0] ALARM_OFF = 2'h0;
    localparam logic [1:0] ALARM_ON = 2'h1;
    localparam logic [1:0] ALARM_RUN_ONLY = 2'h2;
    localparam logic [4:0] SUPPLY_MAX_TRIES = 5'h10;
    localparam logic [4:0] OVER_MAX_TRIES = 5'h03;
    localparam logic [15:0] UV_TIME_MIN = 16'h0003;
    localparam logic [15:0] UV_TIME_MAX = 16'h000A;
    localparam logic [15:0] WAIT_TIME_MIN = 16'h0003;
    localparam logic [15:0] WAIT_TIME_MAX = 16'h03E8;
    localparam logic [15:0] FREQ_THR_MAX = 16'h9C40;

    // reset values
    localparam logic [15:0] RST_UV_TIME = 16'h000A;
    localparam logic [15:0] RST_WAIT_TIME = 16'h000A;
    localparam logic [15:0] RST_FREQ_THR = 16'h0000;

    // ------------------------------------------------------------
    // timing: one tick per 0.1 s
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100000000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int RUN_OK_TICKS = 100;

    typedef struct packed {
        logic power_loss;
        logic low_supply;
        logic over_current;
        logic over_voltage;
    } fault_s;

    typedef struct packed {
        logic restart;
        logic from_zero;
        logic match_freq;
        logic decel_stop;
    } restart_cmd_s;

endpackage : restart_pkg

/* File: src/restart_tick.sv */
// prescaler producing one-cycle 0.1 s ticks
// assumes the control clock and synchronous reset of the controller
`timescale 1ns/1ns
module restart_tick #(
    parameter int CYCLES = 10000000
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    output logic tick
);
    logic [31:0] cnt_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_r <= 32'h0;
        end else if (clk_en) begin
            if (cnt_r == 32'(CYCLES - 1)) begin
                cnt_r <= 32'h0;
            end else begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end

    assign tick = clk_en && (cnt_r == 32'(CYCLES - 1));
endmodule : restart_tick

/* File: src/restart_ctrl.sv */
// supply-fault trip / retry controller
// fault pins come from the power stage asynchronously; config over a
// plain register port on the same clock
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ns
module restart_ctrl #(
    parameter int TICK_CYCLES = restart_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rdata,
    input wire restart_pkg::fault_s fault_pins,
    input wire logic stop_reset_key,
    input wire logic motor_running,
    input wire logic ramping_down,
    input wire logic [15:0] motor_freq,
    input wire logic decel_done,
    output restart_pkg::restart_cmd_s restart_cmd,
    output logic trip,
    output logic alarm,
    output logic power_loss_flag,
    output logic low_supply_flag
);
    typedef enum logic [2:0] {
        ST_RUN, ST_FAULT, ST_WAIT, ST_DECEL, ST_TRIP
    } state_e;

    state_e state_r;
    restart_pkg::fault_s sync1_r, sync2_r;
    logic key1_r, key2_r;
    logic [1:0] restart_mode_select_r, power_fail_alarm_enable_r;
    logic restart_count_policy_r;
    logic [15:0] undervoltage_allow_time_r, retry_wait_time_r;
    logic [15:0] restart_freq_threshold_r;
    logic [4:0] supply_tries_r, over_tries_r;
    logic [15:0] timer_r;
    logic supply_fault_r;
    logic tick;
    logic any_supply, any_over, supply_limit_hit, over_limit_hit;

    function automatic logic [15:0] clamp16(input logic [15:0] v,
            input logic [15:0] lo, input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp16

    restart_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_en(clk_en),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1_r <= '0;
            sync2_r <= '0;
            key1_r <= 1'b0;
            key2_r <= 1'b0;
        end else if (clk_en) begin
            sync1_r <= fault_pins;
            sync2_r <= sync1_r;
            key1_r <= stop_reset_key;
            key2_r <= key1_r;
        end
    end

    assign power_loss_flag = sync2_r.power_loss;
    assign low_supply_flag = sync2_r.low_supply;
    assign any_supply = sync2_r.power_loss || sync2_r.low_supply;
    assign any_over = sync2_r.over_current || sync2_r.over_voltage;
    // policy 00 caps at sixteen, 01 never runs out
    assign supply_limit_hit = !restart_count_policy_r
        && (supply_tries_r >= restart_pkg::SUPPLY_MAX_TRIES);
    assign over_limit_hit =
        over_tries_r >= restart_pkg::OVER_MAX_TRIES;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            restart_mode_select_r <= restart_pkg::MODE_TRIP;
            undervoltage_allow_time_r <= restart_pkg::RST_UV_TIME;
            retry_wait_time_r <= restart_pkg::RST_WAIT_TIME;
            power_fail_alarm_enable_r <= restart_pkg::ALARM_OFF;
            restart_count_policy_r <= 1'b0;
            restart_freq_threshold_r <= restart_pkg::RST_FREQ_THR;
        end else if (clk_en && wr_stb) begin
            unique case (addr)
                restart_pkg::ADDR_MODE: restart_mode_select_r <= wdata[1:0];
                restart_pkg::ADDR_UV_TIME: undervoltage_allow_time_r <=
                    clamp16(wdata, restart_pkg::UV_TIME_MIN,
                        restart_pkg::UV_TIME_MAX);
                restart_pkg::ADDR_WAIT_TIME: retry_wait_time_r <=
                    clamp16(wdata, restart_pkg::WAIT_TIME_MIN,
                        restart_pkg::WAIT_TIME_MAX);
                restart_pkg::ADDR_ALARM_EN:
                    power_fail_alarm_enable_r <= wdata[1:0];
                restart_pkg::ADDR_COUNT_POL:
                    restart_count_policy_r <= wdata[0];
                restart_pkg::ADDR_FREQ_THR: restart_freq_threshold_r <=
                    clamp16(wdata, 16'h0000, restart_pkg::FREQ_THR_MAX);
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata <= 16'h0000;
        end else if (clk_en) begin
            rdata <= 16'h0000;
            if (rd_stb) begin
                unique case (addr)
                    restart_pkg::ADDR_MODE:
                        rdata <= {14'h0, restart_mode_select_r};
                    restart_pkg::ADDR_UV_TIME:
                        rdata <= undervoltage_allow_time_r;
                    restart_pkg::ADDR_WAIT_TIME: rdata <= retry_wait_time_r;
                    restart_pkg::ADDR_ALARM_EN:
                        rdata <= {14'h0, power_fail_alarm_enable_r};
                    restart_pkg::ADDR_COUNT_POL:
                        rdata <= {15'h0, restart_count_policy_r};
                    restart_pkg::ADDR_FREQ_THR:
                        rdata <= restart_freq_threshold_r;
                    restart_pkg::ADDR_STATUS:
                        rdata <= {9'h0, 3'(state_r), sync2_r};
                    restart_pkg::ADDR_COUNTS:
                        rdata <= {3'h0, over_tries_r, 3'h0, supply_tries_r};
                    default: rdata <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // fault / retry sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= ST_RUN;
            timer_r <= 16'h0;
            supply_fault_r <= 1'b0;
            supply_tries_r <= 5'h0;
            over_tries_r <= 5'h0;
        end else if (clk_en) begin
            unique case (state_r)
                ST_RUN: begin
                    if (any_supply || any_over) begin
                        supply_fault_r <= any_supply;
                        timer_r <= 16'h0;
                        if (restart_mode_select_r == restart_pkg::MODE_TRIP)
                        begin
                            state_r <= ST_TRIP;
                        end else if (any_supply ? supply_limit_hit
                                : over_limit_hit) begin
                            state_r <= ST_TRIP;
                        end else begin
                            state_r <= ST_FAULT;
                        end
                    end else if (motor_running) begin
                        // clear counts after sustained normal running
                        if (tick) begin
                            timer_r <= timer_r + 16'h1;
                        end
                        if (timer_r >= 16'(restart_pkg::RUN_OK_TICKS)) begin
                            supply_tries_r <= 5'h0;
                            over_tries_r <= 5'h0;
                            timer_r <= 16'h0;
                        end
                    end else begin
                        timer_r <= 16'h0;
                    end
                end
                ST_FAULT: begin
                    if (tick) begin
                        timer_r <= timer_r + 16'h1;
                    end
                    if (supply_fault_r && sync2_r.low_supply
                            && timer_r >= undervoltage_allow_time_r) begin
                        state_r <= ST_TRIP;
                    end else if (!any_supply && !any_over) begin
                        timer_r <= 16'h0;
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (any_supply || any_over) begin
                        timer_r <= 16'h0;
                        state_r <= ST_FAULT;
                    end else begin
                        if (tick) begin
                            timer_r <= timer_r + 16'h1;
                        end
                        if (timer_r >= retry_wait_time_r) begin
                            timer_r <= 16'h0;
                            if (supply_fault_r) begin
                                supply_tries_r <= supply_tries_r
                                    + {4'h0, !restart_count_policy_r};
                            end else begin
                                over_tries_r <= over_tries_r + 5'h1;
                            end
                            if (restart_mode_select_r ==
                                    restart_pkg::MODE_MATCH_STOP) begin
                                state_r <= ST_DECEL;
                            end else begin
                                state_r <= ST_RUN;
                            end
                        end
                    end
                end
                ST_DECEL: begin
                    if (decel_done) begin
                        state_r <= ST_TRIP;
                    end
                end
                ST_TRIP: begin
                    if (key2_r) begin
                        state_r <= ST_RUN;
                        timer_r <= 16'h0;
                        supply_tries_r <= 5'h0;
                        over_tries_r <= 5'h0;
                    end
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic restart_now;
    assign restart_now = (state_r == ST_WAIT) && !any_supply && !any_over
        && (timer_r >= retry_wait_time_r);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            restart_cmd <= '0;
        end else if (clk_en) begin
            restart_cmd <= '0;
            if (restart_now) begin
                restart_cmd.restart <= 1'b1;
                // slow or mode 01 restarts from zero
                if (restart_mode_select_r == restart_pkg::MODE_ZERO
                        || motor_freq < restart_freq_threshold_r) begin
                    restart_cmd.from_zero <= 1'b1;
                end else begin
                    restart_cmd.match_freq <= 1'b1;
                end
            end
            if (state_r == ST_DECEL) begin
                restart_cmd.decel_stop <= 1'b1;
            end
        end
    end

    assign trip = (state_r == ST_TRIP);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            alarm <= 1'b0;
        end else if (clk_en) begin
            if (state_r != ST_TRIP) begin
                alarm <= 1'b0;
            end else if (!supply_fault_r
                    || restart_mode_select_r == restart_pkg::MODE_TRIP
                    || restart_mode_select_r == restart_pkg::MODE_MATCH_STOP)
            begin
                alarm <= 1'b1;
            end else begin
                unique case (power_fail_alarm_enable_r)
                    restart_pkg::ALARM_ON: alarm <= 1'b1;
                    restart_pkg::ALARM_RUN_ONLY:
                        alarm <= motor_running && !ramping_down;
                    default: alarm <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_trip_holds_key: assert property (@(posedge clk_sys) disable iff (reset)
        trip && !key2_r && clk_en |=> trip)
        else $error("trip released without key");
    a_mode0_no_restart: assert property (@(posedge clk_sys)
        disable iff (reset)
        restart_mode_select_r == restart_pkg::MODE_TRIP && state_r == ST_RUN
        && (any_supply || any_over) && clk_en |=> trip)
        else $error("mode 00 did not trip");
    a_supply_cap: assert property (@(posedge clk_sys) disable iff (reset)
        supply_tries_r <= restart_pkg::SUPPLY_MAX_TRIES)
        else $error("supply retries above sixteen");
    a_over_cap: assert property (@(posedge clk_sys) disable iff (reset)
        over_tries_r <= restart_pkg::OVER_MAX_TRIES)
        else $error("over fault retries above three");
    a_over_fourth: assert property (@(posedge clk_sys) disable iff (reset)
        state_r == ST_RUN && !any_supply && any_over && over_limit_hit
        && restart_mode_select_r != restart_pkg::MODE_TRIP && clk_en
        |=> trip)
        else $error("fourth over fault did not trip");
    a_restart_wait: assert property (@(posedge clk_sys) disable iff (reset)
        restart_cmd.restart |-> $past(timer_r) >= retry_wait_time_r)
        else $error("restart before wait time");
    a_zero_below_thr: assert property (@(posedge clk_sys)
        disable iff (reset)
        restart_now && clk_en && motor_freq < restart_freq_threshold_r
        |=> restart_cmd.from_zero)
        else $error("slow motor not restarted from zero");
    a_uv_timeout: assert property (@(posedge clk_sys) disable iff (reset)
        state_r == ST_FAULT && supply_fault_r && sync2_r.low_supply
        && timer_r >= undervoltage_allow_time_r && clk_en |=> trip)
        else $error("long low supply did not trip");
    a_key_clears: assert property (@(posedge clk_sys) disable iff (reset)
        trip && key2_r && clk_en |=> supply_tries_r == 5'h0
        && over_tries_r == 5'h0 && !trip)
        else $error("reset key did not clear counts");
    a_loss_flag: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en ##1 clk_en ##1 clk_en |-> power_loss_flag
        == $past(fault_pins.power_loss, 2))
        else $error("power loss flag mismatch");
    a_low_flag: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en ##1 clk_en ##1 clk_en |-> low_supply_flag
        == $past(fault_pins.low_supply, 2))
        else $error("low supply flag mismatch");
endmodule : restart_ctrl

/* File: dv/power_stage.sv */
// power stage and motor stand-in for the restart controller
// assumes the bench raises faults on fault_req and holds them as levels
`timescale 1ns/1ns
module power_stage #(
    parameter logic [15:0] FREQ = 16'h1388
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire restart_pkg::fault_s fault_req,
    input wire restart_pkg::restart_cmd_s restart_cmd,
    input wire logic trip,
    output restart_pkg::fault_s fault_pins,
    output logic motor_running,
    output logic ramping_down,
    output logic [15:0] motor_freq,
    output logic decel_done
);
    logic [3:0] decel_cnt_r;

    assign fault_pins = fault_req;
    assign ramping_down = restart_cmd.decel_stop;
    assign motor_freq = FREQ;
    assign decel_done = (decel_cnt_r == 4'h8);

    // motor coasts on any fault or trip and spins up again on restart
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            motor_running <= 1'b1;
        end else if (trip || (fault_req != 4'h0)) begin
            motor_running <= 1'b0;
        end else if (restart_cmd.restart) begin
            motor_running <= 1'b1;
        end
    end

    // standstill is reached a fixed while after deceleration begins
    always_ff @(posedge clk_sys) begin
        if (reset || !restart_cmd.decel_stop) begin
            decel_cnt_r <= 4'h0;
        end else if (decel_cnt_r != 4'hF) begin
            decel_cnt_r <= decel_cnt_r + 4'h1;
        end
    end
endmodule : power_stage

/* File: dv/tb_top.sv */
// self-checking bench for the supply-fault restart controller
// assumes the power-stage model beside it and a tick of 10 cycles
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {
        logic wr;
        logic [3:0] a;
        logic [15:0] d;
        logic [15:0] exp;
    } row_s;
    localparam restart_pkg::fault_s PL = 4'h8;
    localparam restart_pkg::fault_s LS = 4'h4;
    localparam restart_pkg::fault_s OC = 4'h2;
    localparam restart_pkg::fault_s OV = 4'h1;
    logic clk_sys, reset, clk_en, wr_stb, rd_stb, stop_reset_key;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, rv, motor_freq;
    restart_pkg::fault_s fault_req, fault_pins;
    restart_pkg::restart_cmd_s restart_cmd, last_cmd;
    logic trip, alarm, power_loss_flag, low_supply_flag;
    logic motor_running, ramping_down, decel_done, last_dc;
    int n_errors = 0;
    int n_compared = 0;
    int last_dly;
    row_s rows [18] = '{
        '{1'b0, 4'h0, 16'h0000, 16'h0000}, '{1'b0, 4'h1, 16'h0000, 16'h000A},
        '{1'b0, 4'h2, 16'h0000, 16'h000A}, '{1'b0, 4'h3, 16'h0000, 16'h0000},
        '{1'b0, 4'h4, 16'h0000, 16'h0000}, '{1'b0, 4'h5, 16'h0000, 16'h0000},
        '{1'b0, 4'h7, 16'h0000, 16'h0000}, '{1'b0, 4'h6, 16'h0000, 16'h0000},
        '{1'b1, 4'h1, 16'h0014, 16'h000A},
        '{1'b1, 4'h1, 16'h0001, 16'h0003}, '{1'b1, 4'h2, 16'h07D0, 16'h03E8},
        '{1'b1, 4'h2, 16'h0001, 16'h0003}, '{1'b1, 4'h5, 16'hFFFF, 16'h9C40},
        '{1'b1, 4'h3, 16'h0002, 16'h0002}, '{1'b1, 4'h4, 16'h0001, 16'h0001},
        '{1'b1, 4'h7, 16'h00FF, 16'h0000}, '{1'b1, 4'h9, 16'h1234, 16'h0000},
        '{1'b1, 4'h0, 16'h0003, 16'h0003}};

    restart_ctrl #(.TICK_CYCLES(10)) i_dut (.clk_sys, .reset, .clk_en,
        .addr, .wdata, .wr_stb, .rd_stb, .rdata, .fault_pins,
        .stop_reset_key, .motor_running, .ramping_down, .motor_freq,
        .decel_done, .restart_cmd, .trip, .alarm, .power_loss_flag,
        .low_supply_flag);
    power_stage i_stage (.clk_sys, .reset, .fault_req, .restart_cmd, .trip,
        .fault_pins, .motor_running, .ramping_down, .motor_freq, .decel_done);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp,
        input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        rv = rdata;
    endtask : rd

    // one fault episode, then a window that watches for restart and trip
    task automatic try_once(input restart_pkg::fault_s f, input int hold,
        input logic exp_rs, input logic exp_tr);
        logic rs = 1'b0;
        logic tr = 1'b0;
        last_dc = 1'b0;
        @(posedge clk_sys);
        fault_req <= f;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("power_loss_flag", f.power_loss, power_loss_flag);
        chk("low_supply_flag", f.low_supply, low_supply_flag);
        repeat (hold - 3) @(posedge clk_sys);
        fault_req <= 4'h0;
        for (int i = 0; i < 150; i++) begin
            @(posedge clk_sys);
            #1;
            if (!rs && restart_cmd.restart === 1'b1) begin
                rs = 1'b1;
                last_cmd = restart_cmd;
                last_dly = i;
            end
            if (restart_cmd.decel_stop === 1'b1) last_dc = 1'b1;
            if (trip === 1'b1) tr = 1'b1;
        end
        chk("restart", exp_rs, rs);
        chk("trip", exp_tr, tr);
    endtask : try_once

    task automatic key_reset();
        @(posedge clk_sys);
        stop_reset_key <= 1'b1;
        repeat (4) @(posedge clk_sys);
        stop_reset_key <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk("trip", 1'b0, trip);
    endtask : key_reset

    task automatic tally_and_finish();
        $display("compared %0d, wrong %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (30000) @(posedge clk_sys);
        n_errors++;
        $display("watchdog ran out");
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        stop_reset_key = 1'b0;
        clk_en = 1'b1;
        fault_req = 4'h0;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk("register", rows[i].exp, rv);
        end
        $display("test registers done");
        wr(4'h1, 16'h0003);
        wr(4'h5, 16'h0000);
        wr(4'h3, 16'h0001);
        wr(4'h4, 16'h0000);
        wr(4'h0, 16'h0000);
        try_once(OC, 3, 1'b0, 1'b1);
        chk("alarm", 1'b1, alarm);
        key_reset();
        $display("test trip mode done");
        wr(4'h0, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            try_once(i[0] ? OV : OC, 3, 1'b1, 1'b0);
            chk("from_zero", 1'b1, last_cmd.from_zero);
        end
        chk("retry delay ok", 1'b1, last_dly >= 20 && last_dly <= 50);
        rd(4'h7);
        chk("counts", 16'h0300, rv);
        try_once(OV, 3, 1'b0, 1'b1);
        key_reset();
        rd(4'h7);
        chk("counts", 16'h0000, rv);
        $display("test over faults done");
        wr(4'h0, 16'h0002);
        repeat (16) try_once(PL, 3, 1'b1, 1'b0);
        chk("match_freq", 1'b1, last_cmd.match_freq);
        rd(4'h7);
        chk("counts", 16'h0010, rv);
        try_once(PL, 3, 1'b0, 1'b1);
        chk("alarm", 1'b1, alarm);
        key_reset();
        wr(4'h5, 16'hFFFF);
        try_once(LS, 3, 1'b1, 1'b0);
        chk("from_zero", 1'b1, last_cmd.from_zero);
        wr(4'h5, 16'h0000);
        $display("test supply faults done");
        for (int c = 0; c < 3; c++) begin
            wr(4'h3, 16'(c));
            try_once(LS, 60, 1'b0, 1'b1);
            chk("alarm", c == 1, alarm);
            key_reset();
        end
        $display("test alarm codes done");
        wr(4'h0, 16'h0003);
        try_once(OC, 3, 1'b1, 1'b1);
        chk("decel_stop", 1'b1, last_dc);
        key_reset();
        wr(4'h0, 16'h0001);
        wr(4'h4, 16'h0001);
        repeat (17) try_once(PL, 3, 1'b1, 1'b0);
        try_once(OC, 3, 1'b1, 1'b0);
        rd(4'h7);
        chk("counts", 16'h0100, rv);
        repeat (1100) @(posedge clk_sys);
        rd(4'h7);
        chk("counts", 16'h0000, rv);
        $display("test stop mode and no limit done");
        wr(4'h0, 16'h0000);
        clk_en <= 1'b0;
        fault_req <= OC;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("frozen trip", 1'b0, trip);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
        chk("trip", 1'b1, trip);
        @(posedge clk_sys);
        fault_req <= 4'h0;
        key_reset();
        $display("test clock enable done");
        tally_and_finish();
    end
endmodule : tb_top
